// *** hdl/mrb_pkg.sv ***
package mrb_pkg;

    localparam int unsigned MRB_ADDR_W = 24;
    localparam int unsigned MRB_DATA_W = 16;
    localparam int unsigned MRB_WIN_W = 12;
    // window bases for the two map settings
    localparam logic [23:0] MRB_BASE_MAP0 = 24'h7F_F000;
    localparam logic [23:0] MRB_BASE_MAP1 = 24'hFF_F000;
    localparam logic [11:0] MRB_WIN_MASK = 12'hFFF;
    // configuration register offset in the window and map-select bit
    localparam logic [11:0] MRB_CFG_OFS = 12'h000;
    localparam int unsigned MRB_CFG_MAP_BIT = 6;
    localparam logic MRB_MAP_RST = 1'b1;
    // window slots, 64 words of 2 bytes from 0x000
    localparam int unsigned MRB_SLOT_N = 64;
    localparam logic [63:0] MRB_SV_ONLY_RST = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [15:0] MRB_ZERO16 = 16'h0000;

    typedef struct packed {
        logic req;
        logic wr;
        logic sv;
        logic [23:0] addr;
        logic [15:0] wdata;
    } mrb_req_s;

    typedef struct packed {
        logic hit;
        logic ext;
        logic priv_err;
        logic [11:0] offset;
    } mrb_dec_s;

endpackage

// *** hdl/mrb_decode.sv ***
`timescale 1ns/10ps
`default_nettype none
module mrb_decode
    import mrb_pkg::*;
(
    // request and map state
    input wire mrb_req_s req,
    input wire logic map_sel,
    input wire logic narrow_cpu,
    input wire logic [63:0] sv_only,
    // decode result
    output mrb_dec_s dec
);
    logic [23:0] eff_addr;
    logic [23:0] base;
    logic in_win;
    logic sv_eff;
    logic [5:0] slot;

    always_comb
    begin
        eff_addr = req.addr;
        if (narrow_cpu)
        begin
            eff_addr[23:20] = {4{req.addr[19]}}; // RQ6
        end
        base = map_sel ? MRB_BASE_MAP1 : MRB_BASE_MAP0; // RQ2 RQ3
        in_win = (eff_addr & ~{12'h000, MRB_WIN_MASK}) == base; // RQ1
        sv_eff = req.sv | narrow_cpu;
        slot = eff_addr[6:1];
        dec.offset = eff_addr[11:0] & MRB_WIN_MASK;
        dec.hit = req.req & in_win;
        dec.ext = req.req & ~in_win; // RQ11
        dec.priv_err = req.req & in_win & ~sv_eff
            & (eff_addr[11:7] == 5'h00) & sv_only[slot]; // RQ8
    end
endmodule
`default_nettype wire

// *** hdl/mrb_map.sv ***
`timescale 1ns/10ps
`default_nettype none
// Contract
// RQ1: all module control registers sit in one 4-Kbyte window.
// RQ2: with map select clear the window is 7FF000 to 7FFFFF.
// RQ3: with map select set the window is FFF000 to FFFFFF.
// RQ4: map select resets to one and takes only the first write after reset.
// RQ5: boot software should write one to map select to keep it set.
// RQ6: on narrow cpus address lines 23 to 20 follow line 19 unless driven.
// RQ7: on narrow cpus a cleared map select hides the window until reset.
// RQ8: supervisor-only slots need supervisor access, others programmable.
// RQ9: the module bus carries 24 address and 16 data lines.
// RQ10: a narrow cpu always accesses at supervisor level.
// RQ11: addresses outside the window go to external decoding.
module mrb_map
    import mrb_pkg::*;
#(
    parameter logic NARROW_CPU = 1'b0
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,

    // module bus request, 24 address and 16 data lines
    input wire logic bus_req,
    input wire logic bus_wr,
    input wire logic bus_sv,
    input wire logic [MRB_ADDR_W-1:0] bus_addr, // RQ9
    input wire logic [MRB_DATA_W-1:0] bus_wdata, // RQ9

    // privilege programming for the shared slots
    input wire logic priv_wr,
    input wire logic [5:0] priv_slot,
    input wire logic priv_sv_only,

    // ext address lines 23..20 and their external drive
    input wire logic [3:0] ext_addr_hi_in,
    output logic [3:0] ext_addr_hi_out,
    output logic [3:0] ext_addr_hi_oe,

    // decode results
    output logic reg_hit,
    output logic reg_wr,
    output logic [11:0] reg_offset,
    output logic [MRB_DATA_W-1:0] reg_wdata,
    output logic ext_hit,
    output logic priv_fault,
    output logic module_map_select,
    output logic [MRB_DATA_W-1:0] integration_config_register
);

    // whole block state, registered in one place
    typedef struct packed {
        logic map_sel;
        logic map_written;
        logic [15:0] cfg;
        logic [63:0] sv_only;
        logic hit;
        logic wr;
        logic [11:0] offset;
        logic [15:0] wdata;
        logic ext;
        logic perr;
        logic [3:0] hi_out;
        logic [3:0] hi_oe;
    } mrb_state_s;

    mrb_state_s st_reg;
    mrb_state_s st_next;
    mrb_req_s req;
    mrb_dec_s dec;
    logic cfg_wr;
    logic acc_ok;

    // in window and privileged: the access reaches a register
    function automatic logic access_ok(input mrb_dec_s d);
        return d.hit & ~d.priv_err;
    endfunction

    // config word as software sees it, only the map bit is live
    function automatic logic [MRB_DATA_W-1:0] cfg_word(input logic map);
        logic [MRB_DATA_W-1:0] w;
        w = MRB_ZERO16;
        w[MRB_CFG_MAP_BIT] = map;
        return w;
    endfunction

    // narrow cpu: upper lines come from the resolved pins
    function automatic logic [MRB_ADDR_W-1:0] bus_view(
        input logic [MRB_ADDR_W-1:0] a,
        input logic [3:0] ext_hi,
        input logic narrow
    );
        logic [MRB_ADDR_W-1:0] v;
        v = a;
        if (narrow)
        begin
            v[23:20] = ext_hi;
        end
        return v;
    endfunction

    // request as the decoder sees it
    always_comb
    begin
        req.req = bus_req;
        req.wr = bus_wr;
        req.sv = bus_sv;
        req.addr = bus_view(bus_addr, ext_addr_hi_in, NARROW_CPU);
        req.wdata = bus_wdata;
    end

    // window, privilege and outside decode
    mrb_decode u_decode (
        .req(req),
        .map_sel(st_reg.map_sel),
        .narrow_cpu(NARROW_CPU),
        .sv_only(st_reg.sv_only),
        .dec(dec)
    );

    assign acc_ok = access_ok(dec);
    assign cfg_wr = acc_ok & bus_wr
        & (dec.offset == MRB_CFG_OFS);

    always_comb
    begin
        st_next = st_reg;

        // map select accepts one write only
        if (cfg_wr && !st_reg.map_written)
        begin
            st_next.map_sel = bus_wdata[MRB_CFG_MAP_BIT]; // RQ4
            st_next.map_written = 1'b1; // RQ4
        end
        st_next.cfg = cfg_word(st_next.map_sel);

        // on a wide cpu the shared slots take their privilege from software
        for (int i = 0; i < MRB_SLOT_N; i++)
        begin
            if (priv_wr && !NARROW_CPU && priv_slot == 6'(i))
            begin
                st_next.sv_only[i] = priv_sv_only; // RQ8
            end
        end

        st_next.hit = acc_ok; // RQ1
        st_next.wr = acc_ok & bus_wr;
        if (acc_ok)
        begin
            st_next.offset = dec.offset;
            st_next.wdata = bus_wdata;
        end
        else
        begin
            st_next.offset = 12'h000;
            st_next.wdata = MRB_ZERO16;
        end
        st_next.ext = dec.ext; // RQ11
        st_next.perr = dec.priv_err; // RQ8

        // narrow cpu with map cleared: window out of reach
        if (NARROW_CPU && !st_reg.map_sel)
        begin
            st_next.hit = 1'b0; // RQ7
            st_next.wr = 1'b0;
            st_next.offset = 12'h000;
            st_next.wdata = MRB_ZERO16;
        end

        // lines 23..20 mirror line 19 when nobody else drives them
        st_next.hi_out = {4{bus_addr[19]}}; // RQ6
        if (NARROW_CPU && bus_req)
        begin
            st_next.hi_oe = 4'hf; // RQ6
        end
        else
        begin
            st_next.hi_oe = 4'h0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            // map bit back to one, every slot supervisor-only
            st_reg.map_sel <= MRB_MAP_RST; // RQ4
            st_reg.map_written <= 1'b0;
            st_reg.cfg <= cfg_word(MRB_MAP_RST);
            st_reg.sv_only <= MRB_SV_ONLY_RST;
            st_reg.hit <= 1'b0;
            st_reg.wr <= 1'b0;
            st_reg.offset <= 12'h000;
            st_reg.wdata <= MRB_ZERO16;
            st_reg.ext <= 1'b0;
            st_reg.perr <= 1'b0;
            st_reg.hi_out <= 4'h0;
            st_reg.hi_oe <= 4'h0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // registered results
    assign reg_hit = st_reg.hit;
    assign reg_wr = st_reg.wr;
    assign reg_offset = st_reg.offset;
    assign reg_wdata = st_reg.wdata;
    assign ext_hit = st_reg.ext;
    assign priv_fault = st_reg.perr;
    assign module_map_select = st_reg.map_sel;
    assign integration_config_register = st_reg.cfg;

    // address line drive
    assign ext_addr_hi_out = st_reg.hi_out;
    assign ext_addr_hi_oe = st_reg.hi_oe;
endmodule
`default_nettype wire

// *** tb/mrb_map_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none
module mrb_map_asserts
    import mrb_pkg::*;
#(
    parameter logic NARROW = 1'b0
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // request
    input wire logic bus_req,
    input wire logic bus_wr,
    input wire logic bus_sv,
    input wire logic [23:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    // results
    input wire logic reg_hit,
    input wire logic [11:0] reg_offset,
    input wire logic ext_hit,
    input wire logic priv_fault,
    input wire logic module_map_select,
    input wire logic [15:0] integration_config_register,
    input wire logic [3:0] ext_addr_hi_out,
    input wire logic [3:0] ext_addr_hi_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    wire logic [23:0] eff_addr = NARROW ?
        {{4{bus_addr[19]}}, bus_addr[19:0]} : bus_addr;
    wire logic sv_eff = bus_sv | NARROW;
    wire logic in_win = eff_addr[23:12] ==
        (module_map_select ? 12'hfff : 12'h7ff);
    property p_win;
        bus_req && sv_eff && in_win |=>
            reg_hit && reg_offset == $past(bus_addr[11:0]);
    endproperty
    a_win: assert property (p_win) else $error("window hit");
    property p_ext;
        bus_req && !in_win |=> ext_hit && !reg_hit && !priv_fault;
    endproperty
    a_ext: assert property (p_ext) else $error("outside");
    property p_priv;
        priv_fault |->
            $past(bus_req && !sv_eff && in_win && bus_addr[11:7] == 5'h00);
    endproperty
    a_priv: assert property (p_priv) else $error("fault cause");
    property p_user;
        bus_req && !sv_eff && in_win && bus_addr[11:7] != 5'h00 |=> reg_hit;
    endproperty
    a_user: assert property (p_user) else $error("user hit");
    property p_once;
        $rose(module_map_select) |-> $past(!rst_b);
    endproperty
    a_once: assert property (p_once) else $error("map set");
    property p_clr;
        $fell(module_map_select) |-> $past(bus_req && bus_wr && in_win
            && bus_addr[11:0] == 12'h000 && !bus_wdata[6]);
    endproperty
    a_clr: assert property (p_clr) else $error("map clear");
    property p_cfg;
        integration_config_register == {9'h000, module_map_select, 6'h00};
    endproperty
    a_cfg: assert property (p_cfg) else $error("cfg value");
    property p_idle;
        !bus_req |=> !reg_hit && !ext_hit && !priv_fault;
    endproperty
    a_idle: assert property (p_idle) else $error("idle");
    property p_hi;
        bus_req |=> ext_addr_hi_oe == {4{NARROW}}
            && ext_addr_hi_out == {4{$past(bus_addr[19])}};
    endproperty
    a_hi: assert property (p_hi) else $error("upper lines");
    property p_hide;
        NARROW && !$past(module_map_select) |-> !reg_hit;
    endproperty
    a_hide: assert property (p_hide) else $error("hidden window");
endmodule
bind mrb_map mrb_map_asserts #(.NARROW(NARROW_CPU)) u_chk (.*);
`default_nettype wire

// *** tb/mrb_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module mrb_cpu_model
    import mrb_pkg::*;
(
    // module bus master side
    input wire logic clk_sys,
    output logic bus_req,
    output logic bus_wr,
    output logic bus_sv,
    output logic [23:0] bus_addr,
    output logic [15:0] bus_wdata
);
    initial {bus_req, bus_wr, bus_sv, bus_addr, bus_wdata} = '0;
    task automatic access(input logic [1:0] ctl, input logic [23:0] a,
        input logic [15:0] d);
        {bus_req, bus_wr, bus_sv, bus_addr, bus_wdata} = {1'b1, ctl, a, d};
        @(negedge clk_sys);
    endtask
    // released lines show no stale value
    task automatic idle();
        bus_req = 1'b0;
        {bus_addr, bus_wdata} = ~{bus_addr, bus_wdata};
        @(negedge clk_sys);
    endtask
endmodule
`default_nettype wire

// *** tb/test_module_register_block_map.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_module_register_block_map
    import mrb_pkg::*;
;
    typedef struct packed {
        logic [1:0] ctl;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [3:0] exp;
    } mrb_row_s;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic priv_wr = 1'b0;
    logic [5:0] priv_slot = 6'h00;
    logic priv_sv_only = 1'b1;
    logic bus_req, bus_wr, bus_sv, reg_hit, reg_wr, ext_hit, priv_fault;
    logic module_map_select;
    logic [23:0] bus_addr;
    logic [15:0] bus_wdata, reg_wdata, integration_config_register;
    logic [11:0] reg_offset;
    logic [3:0] hi_out, hi_oe, n_hi_out, n_hi_oe;
    logic n_hit, n_ext, n_perr, n_map;
    wire logic [15:0] flags = {12'h000, reg_hit, ext_hit, priv_fault,
        module_map_select};
    wire logic [15:0] n_flags = {12'h000, n_hit, n_ext, n_perr, n_map};
    wire logic [15:0] n_hi = {8'h00, n_hi_oe, n_hi_out};
    int err_total = 0;
    int check_count = 0;
    mrb_row_s rows [9] = '{'{2'h1, 24'hff_f000, 16'h0000, 4'h9},
        '{2'h1, 24'h7f_f7fe, 16'h0000, 4'h5}, '{2'h0, 24'hff_f07e, 16'h0000, 4'h3},
        '{2'h0, 24'hff_f080, 16'h0000, 4'h9}, '{2'h3, 24'hff_f000, 16'h0000, 4'h8},
        '{2'h3, 24'h7f_f000, 16'h0040, 4'h8}, '{2'h1, 24'hff_fffe, 16'h0000, 4'h4},
        '{2'h1, 24'h7f_effe, 16'h0000, 4'h4}, '{2'h1, 24'h7f_fffe, 16'h0000, 4'h8}};
    always #20 clk_sys = ~clk_sys;
    mrb_map u_dut (.*, .ext_addr_hi_in(4'h0), .ext_addr_hi_out(hi_out),
        .ext_addr_hi_oe(hi_oe));
    mrb_map #(.NARROW_CPU(1'b1)) u_dut_n (.clk_sys(clk_sys), .rst_b(rst_b),
        .bus_req(bus_req), .bus_wr(bus_wr), .bus_sv(bus_sv),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .priv_wr(priv_wr),
        .priv_slot(priv_slot), .priv_sv_only(priv_sv_only),
        .ext_addr_hi_in({4{bus_addr[19]}}), .ext_addr_hi_out(n_hi_out),
        .ext_addr_hi_oe(n_hi_oe), .reg_hit(n_hit), .reg_wr(),
        .reg_offset(), .reg_wdata(), .ext_hit(n_ext), .priv_fault(n_perr),
        .module_map_select(n_map), .integration_config_register());
    mrb_cpu_model u_cpu (.*);
    task automatic chk(input string name, input logic [15:0] exp, got);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch %s exp %h got %h", name, exp, got);
        end
    endtask
    task automatic run(input mrb_row_s r);
        logic [11:0] ofs;
        ofs = r.exp[3] ? r.addr[11:0] : 12'h000;
        u_cpu.access(r.ctl, r.addr, r.wdata);
        chk("flags", {12'h000, r.exp}, flags);
        chk("cfg", {9'h000, r.exp[0], 6'h00}, integration_config_register);
        chk("wr", {15'h0000, r.exp[3] & r.ctl[1]}, {15'h0000, reg_wr});
        chk("ofs", {4'h0, ofs}, {4'h0, reg_offset});
        chk("wdata", r.exp[3] ? r.wdata : 16'h0000, reg_wdata);
        chk("hi", {8'h00, 4'h0, {4{r.addr[19]}}}, {8'h00, hi_oe, hi_out});
    endtask
    task automatic run_n(input logic [1:0] ctl, input logic [23:0] a,
        input logic [15:0] d, input logic [3:0] exp);
        u_cpu.access(ctl, a, d);
        chk("narrow", {12'h000, exp}, n_flags);
        chk("n_hi", {8'h00, 4'hf, {4{a[19]}}}, n_hi);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge clk_sys);
        rst_b = 1'b1;
        foreach (rows[i]) run(rows[i]);
        u_cpu.idle();
        priv_wr = 1'b1;
        priv_slot = 6'h08;
        priv_sv_only = 1'b0;
        @(negedge clk_sys);
        priv_wr = 1'b0;
        run('{2'h0, 24'h7f_f010, 16'h0000, 4'h8});
        u_cpu.idle();
        rst_b = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        run('{2'h0, 24'hff_f010, 16'h0000, 4'h3});
        run('{2'h3, 24'hff_f000, 16'h0040, 4'h9});
        run('{2'h3, 24'hff_f000, 16'h0000, 4'h9});
        u_cpu.idle();
        rst_b = 1'b0;
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        run_n(2'h0, 24'h0f_f010, 16'h0000, 4'h9);
        run_n(2'h3, 24'h0f_f000, 16'h0000, 4'h8);
        run_n(2'h1, 24'h7f_f000, 16'h0000, 4'h4);
        run_n(2'h1, 24'h70_0000, 16'h0000, 4'h4);
        final_report();
    end
endmodule
`default_nettype wire
